// *** hw/itc_pkg.sv ***
// Constants shared by the input terminal command logic
package itc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL  = 8'h00;
    localparam logic [7:0] ADR_FSEL0 = 8'h04;
    localparam logic [7:0] ADR_STAT  = 8'h10;
    localparam logic [7:0] ADR_HOLDF = 8'h14;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_FREF_LSB = 0;
    localparam int CTRL_RUN_LSB  = 4;
    localparam int CTRL_HMEM_BIT = 8;
    localparam logic [2:0] FREF_SRC_RST = 3'h1;
    localparam logic [1:0] RUN_SRC_RST  = 2'h1;
    localparam logic       HMEM_RST     = 1'b0;
    localparam logic [2:0] FREF_SRC_MAX = 3'h4;
    localparam logic [1:0] RUN_SRC_MAX  = 2'h3;
    localparam int STAT_LOCAL_BIT = 0;
    localparam int STAT_BB_BIT    = 1;
    localparam int STAT_HOLD_BIT  = 2;
    localparam int STAT_ERR_BIT   = 3;
    localparam int STAT_RUN_BIT   = 4;

    // ------------------------------------------------------------
    // Source codes and terminal function codes
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_PANEL  = 3'h0;
    localparam logic [2:0] SRC_ANALOG = 3'h1;
    localparam logic [2:0] SRC_COMM   = 3'h2;
    localparam logic [2:0] SRC_OPTION = 3'h3;
    localparam logic [2:0] SRC_PULSE  = 3'h4;
    localparam logic [7:0] FN_LOCREM  = 8'h01;
    localparam logic [7:0] FN_BB_NO   = 8'h08;
    localparam logic [7:0] FN_BB_NC   = 8'h09;
    localparam logic [7:0] FN_RHOLD   = 8'h0A;
    localparam logic [7:0] FN_NONE    = 8'h0F;
    localparam logic [7:0] FN_UP      = 8'h10;
    localparam logic [7:0] FN_DOWN    = 8'h11;
endpackage

// *** hw/itc_func_if.sv ***
// Carrier between terminal function decoder and command logic
`timescale 1ns/100ps
interface itc_func_if #(parameter int N_IN = 10);
    logic [N_IN-1:0]      term_on;
    logic [N_IN-1:0][7:0] fsel;
    logic                 lr_assigned;
    logic                 lr_on;
    logic                 bb_active;
    logic                 hold_assigned;
    logic                 hold_on;
    logic                 updown_assigned;
    modport dec (input term_on, fsel, output lr_assigned, lr_on, bb_active,
                 hold_assigned, hold_on, updown_assigned);
    modport top (output term_on, fsel, input lr_assigned, lr_on, bb_active,
                 hold_assigned, hold_on, updown_assigned);
endinterface

// *** hw/itc_sync.sv ***
// Two-stage synchroniser for contact and panel pins
`timescale 1ns/100ps
module itc_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
    } itc_sync_s;

    itc_sync_s q, d;

    // First stage feeds only the second stage
    always_comb begin
        d.ff1 = async_i;
        d.ff2 = q.ff1;
        if (srst) begin
            d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        q <= d;
    end

    assign sync_o = q.ff2;
endmodule // itc_sync

// *** hw/itc_func_dec.sv ***
// Decodes terminal function selections against contact states
`timescale 1ns/100ps
module itc_func_dec #(
    parameter int N_IN = 10
) (
    itc_func_if.dec fi
);
    logic [N_IN-1:0] m_lr, m_lr_on, m_bb, m_hold, m_hold_on, m_ud;

    // One decode slice per terminal
    for (genvar i = 0; i < N_IN; i++) begin : g_term
        assign m_lr[i]      = fi.fsel[i] == itc_pkg::FN_LOCREM;
        assign m_lr_on[i]   = m_lr[i] & fi.term_on[i];
        assign m_bb[i]      = ((fi.fsel[i] == itc_pkg::FN_BB_NO) & fi.term_on[i]) |
                              ((fi.fsel[i] == itc_pkg::FN_BB_NC) & ~fi.term_on[i]);
        assign m_hold[i]    = fi.fsel[i] == itc_pkg::FN_RHOLD;
        assign m_hold_on[i] = m_hold[i] & fi.term_on[i];
        assign m_ud[i]      = (fi.fsel[i] == itc_pkg::FN_UP) |
                              (fi.fsel[i] == itc_pkg::FN_DOWN);
    end

    // Several terminals with one function act as a wired OR
    assign fi.lr_assigned     = |m_lr;
    assign fi.lr_on           = |m_lr_on;
    assign fi.bb_active       = |m_bb;
    assign fi.hold_assigned   = |m_hold;
    assign fi.hold_on         = |m_hold_on;
    assign fi.updown_assigned = |m_ud;
endmodule // itc_func_dec

// *** hw/itc_top.sv ***
// Command selection, baseblock and ramp hold for contact inputs
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/100ps
// Summary of operation
// - Local/remote follows terminal with function 1
// - Local uses panel; remote uses source selections
// - Reference source 0..4, reset value 1
// - Run source 0..3, reset value 1
// - Panel key toggles only without terminal function
// - Function 8 inhibits output while ON
// - Function 9 inhibits output while OFF
// - After baseblock, search toward prior reference
// - Ramp hold latches output frequency while ON
// - Hold release resumes normal ramping
// - Hold memory picks zero or held restart
// - Hold memory needs hold or up/down assigned
// - Held frequency kept in retained storage
// - Memory off: run with hold forces zero
// - Hold plus up/down flags selection error
module itc_top #(
    parameter int N_IN   = 10,
    parameter int FREQ_W = 16
) (
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic [N_IN-1:0]   multi_input_terminals,
    input  wire logic              panel_key_in,
    input  wire logic              panel_run_in,
    input  wire logic              seq_run_in,
    input  wire logic              comm_run_i,
    input  wire logic              opt_run_i,
    input  wire logic [FREQ_W-1:0] panel_freq_i,
    input  wire logic [FREQ_W-1:0] analog_freq_i,
    input  wire logic [FREQ_W-1:0] comm_freq_i,
    input  wire logic [FREQ_W-1:0] opt_freq_i,
    input  wire logic [FREQ_W-1:0] pulse_freq_i,
    input  wire logic [FREQ_W-1:0] out_freq_i,
    output logic                   run_cmd_o,
    output logic      [FREQ_W-1:0] freq_ref_o,
    output logic                   local_mode_o,
    output logic                   out_inhibit_o,
    output logic                   search_req_o,
    output logic      [FREQ_W-1:0] search_freq_o,
    output logic                   ramp_hold_o,
    output logic      [FREQ_W-1:0] hold_freq_o,
    output logic                   invalid_input_sel_error_o
);
    localparam int NW = (N_IN + 3) / 4;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdat;
        logic [2:0]           fsrc;
        logic [1:0]           rsrc;
        logic                 hmem;
        logic [N_IN-1:0][7:0] fsel;
        logic                 key_prev;
        logic                 local_m;
        logic                 run;
        logic [FREQ_W-1:0]    fref;
        logic                 bb;
        logic                 ss;
        logic [FREQ_W-1:0]    sfreq;
        logic                 hold;
        logic [FREQ_W-1:0]    hfreq;
        logic                 err;
        logic [FREQ_W-1:0]    nvf;
    } itc_state_s;

    itc_state_s q, d;

    logic [N_IN+2:0] pins_s;
    logic            key_s, prun_s, srun_s;
    logic            key_rise, run_rise, mem1;
    logic [31:0]     rd_word, wmask;

    itc_func_if #(.N_IN(N_IN)) fi ();

    // ------------------------------------------------------------
    // Pin synchronisers and function decode
    // ------------------------------------------------------------
    itc_sync #(.W(N_IN + 3)) u_sync (
        .mclk    (mclk),
        .srst    (srst),
        .async_i ({seq_run_in, panel_run_in, panel_key_in, multi_input_terminals}),
        .sync_o  (pins_s)
    );

    itc_func_dec #(.N_IN(N_IN)) u_dec (
        .fi (fi.dec)
    );

    assign fi.term_on = pins_s[N_IN-1:0];
    assign fi.fsel    = q.fsel;
    assign key_s      = pins_s[N_IN];
    assign prun_s     = pins_s[N_IN+1];
    assign srun_s     = pins_s[N_IN+2];
    assign key_rise   = key_s & ~q.key_prev;
    assign run_rise   = d.run & ~q.run;
    // Memory selection is dead unless hold or up/down is assigned
    assign mem1 = q.hmem & (fi.hold_assigned | fi.updown_assigned);

    // ------------------------------------------------------------
    // Register read mux and byte-lane mask
    // ------------------------------------------------------------
    always_comb begin
        rd_word = '0;
        if (wb_adr_i == itc_pkg::ADR_CTRL) begin
            rd_word[itc_pkg::CTRL_FREF_LSB +: 3] = q.fsrc;
            rd_word[itc_pkg::CTRL_RUN_LSB +: 2]  = q.rsrc;
            rd_word[itc_pkg::CTRL_HMEM_BIT]      = q.hmem;
        end else if (wb_adr_i == itc_pkg::ADR_STAT) begin
            rd_word[itc_pkg::STAT_LOCAL_BIT] = q.local_m;
            rd_word[itc_pkg::STAT_BB_BIT]    = q.bb;
            rd_word[itc_pkg::STAT_HOLD_BIT]  = q.hold;
            rd_word[itc_pkg::STAT_ERR_BIT]   = q.err;
            rd_word[itc_pkg::STAT_RUN_BIT]   = q.run;
        end else if (wb_adr_i == itc_pkg::ADR_HOLDF) begin
            rd_word[FREQ_W-1:0] = q.nvf;
        end
        for (int k = 0; k < N_IN; k++) begin
            if (wb_adr_i == itc_pkg::ADR_FSEL0 + 8'((k / 4) * 4)) begin
                rd_word[(k % 4) * 8 +: 8] = q.fsel[k];
            end
        end
        for (int b = 0; b < 4; b++) begin
            wmask[b * 8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wv;
        wv = (rd_word & ~wmask) | (wb_dat_i & wmask);
        d  = q;

        // Classic slave: one wait state, ack for one cycle
        d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
        if (d.ack) begin
            d.rdat = rd_word;
        end
        // Write lands on the edge where the master sees ack
        if (wb_cyc_i & wb_stb_i & wb_we_i & q.ack) begin
            if (wb_adr_i == itc_pkg::ADR_CTRL) begin
                // Out-of-range codes are dropped, old value kept
                if (wv[itc_pkg::CTRL_FREF_LSB +: 3] <= itc_pkg::FREF_SRC_MAX) begin
                    d.fsrc = wv[itc_pkg::CTRL_FREF_LSB +: 3];
                end
                d.rsrc = wv[itc_pkg::CTRL_RUN_LSB +: 2];
                d.hmem = wv[itc_pkg::CTRL_HMEM_BIT];
            end
            for (int k = 0; k < N_IN; k++) begin
                if (wb_adr_i == itc_pkg::ADR_FSEL0 + 8'((k / 4) * 4)) begin
                    d.fsel[k] = wv[(k % 4) * 8 +: 8];
                end
            end
        end

        // Local/remote: terminal owns it, else the panel key toggles
        d.key_prev = key_s;
        if (fi.lr_assigned) begin
            d.local_m = fi.lr_on;
        end else if (key_rise) begin
            d.local_m = ~q.local_m;
        end

        // Source muxes; remote uses the two selections
        if (q.local_m) begin
            d.run  = prun_s;
            d.fref = panel_freq_i;
        end else begin
            case (q.rsrc)
                2'h0:    d.run = prun_s;
                2'h1:    d.run = srun_s;
                2'h2:    d.run = comm_run_i;
                default: d.run = opt_run_i;
            endcase
            case (q.fsrc)
                itc_pkg::SRC_PANEL:  d.fref = panel_freq_i;
                itc_pkg::SRC_ANALOG: d.fref = analog_freq_i;
                itc_pkg::SRC_COMM:   d.fref = comm_freq_i;
                itc_pkg::SRC_OPTION: d.fref = opt_freq_i;
                default:             d.fref = pulse_freq_i;
            endcase
        end

        // Baseblock: remember reference at entry, pulse search at exit
        d.bb = fi.bb_active;
        if (fi.bb_active & ~q.bb) begin
            d.sfreq = q.fref;
        end
        d.ss = q.bb & ~fi.bb_active;

        // Ramp hold: freeze at entry, release lets ramp resume
        d.hold = fi.hold_on;
        if (fi.hold_on & ~q.hold) begin
            d.hfreq = out_freq_i;
        end
        if (~d.run & q.run & ~mem1) begin
            d.hfreq = '0;
        end
        // Run edge under hold wins over the capture at hold entry
        if (d.run & ~q.run & fi.hold_on) begin
            d.hfreq = mem1 ? q.nvf : '0;
        end
        if (mem1 & fi.hold_on) begin
            d.nvf = d.hfreq;
        end
        d.err = fi.hold_assigned & fi.updown_assigned;

        // Retained frequency survives reset like backed-up storage
        if (srst) begin
            d       = '0;
            d.fsrc  = itc_pkg::FREF_SRC_RST;
            d.rsrc  = itc_pkg::RUN_SRC_RST;
            d.hmem  = itc_pkg::HMEM_RST;
            d.fsel  = {N_IN{itc_pkg::FN_NONE}};
            d.nvf   = q.nvf;
        end
    end

    always_ff @(posedge mclk) begin
        q <= d;
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign wb_ack_o                  = q.ack;
    assign wb_dat_o                  = q.rdat;
    assign run_cmd_o                 = q.run;
    assign freq_ref_o                = q.fref;
    assign local_mode_o              = q.local_m;
    assign out_inhibit_o             = q.bb;
    assign search_req_o              = q.ss;
    assign search_freq_o             = q.sfreq;
    assign ramp_hold_o               = q.hold;
    assign hold_freq_o               = q.hfreq;
    assign invalid_input_sel_error_o = q.err;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // Own view of the baseblock contacts, kept apart from the decoder it checks
    logic [N_IN-1:0] no_shut, nc_open;
    for (genvar t = 0; t < N_IN; t++) begin : g_bb_chk
        assign no_shut[t] = (q.fsel[t] == itc_pkg::FN_BB_NO) & pins_s[t];
        assign nc_open[t] = (q.fsel[t] == itc_pkg::FN_BB_NC) & ~pins_s[t];
    end

    sequence bb_exit_s;
        q.bb ##1 !q.bb;
    endsequence
    sequence one_pulse_s;
        q.ss ##1 !q.ss;
    endsequence

    lr_follow_a: assert property (fi.lr_assigned |=> q.local_m == $past(fi.lr_on))
        else $error("local mode does not follow terminal");
    local_src_a: assert property (q.local_m |=> q.run == $past(prun_s))
        else $error("local mode not using panel run");
    fref_rng_a: assert property (q.fsrc <= itc_pkg::FREF_SRC_MAX)
        else $error("reference source out of range");
    key_toggle_a: assert property (!fi.lr_assigned && key_rise |=> $changed(q.local_m))
        else $error("panel key did not toggle");
    bb_no_a: assert property ((|no_shut) |=> q.bb)
        else $error("normally-open baseblock missed");
    bb_nc_a: assert property ((|nc_open) |=> q.bb)
        else $error("normally-closed baseblock missed");
    bb_search_a: assert property (bb_exit_s |-> one_pulse_s)
        else $error("search request not a single pulse");
    bb_freq_a: assert property (q.bb |=> $stable(q.sfreq))
        else $error("search frequency changed during baseblock");
    hold_frz_a: assert property (q.hold && fi.hold_on && !run_rise && d.run
                                 |=> $stable(q.hfreq))
        else $error("held frequency moved");
    hold_zero_a: assert property (run_rise && fi.hold_on && !mem1 |=> q.hfreq == '0)
        else $error("run under hold did not zero");
    nv_keep_a: assert property (mem1 && fi.hold_on |=> q.nvf == q.hfreq)
        else $error("retained frequency not stored");
    sel_err_a: assert property (fi.hold_assigned && fi.updown_assigned |=> q.err)
        else $error("selection error not flagged");
    ack_pulse_a: assert property (q.ack |=> !q.ack)
        else $error("ack held longer than one cycle");
    run_comm_a: assert property (!q.local_m && q.rsrc == 2'h2
                                 |=> q.run == $past(comm_run_i))
        else $error("remote run not taken from communications");
    fref_pulse_a: assert property (!q.local_m && q.fsrc == itc_pkg::SRC_PULSE
                                   |=> q.fref == $past(pulse_freq_i))
        else $error("remote reference not taken from pulse input");
    mem_dead_a: assert property (!fi.hold_assigned && !fi.updown_assigned
                                 && q.run && !d.run |=> q.hfreq == '0)
        else $error("held frequency kept without hold or up/down");
endmodule // itc_top

// *** verif/itc_contacts.sv ***
// Behavioural model of the contact switches and operator panel keys
`timescale 1ns/100ps
module itc_contacts #(
    parameter int N_IN = 10
) (
    input  wire logic            mclk,
    input  wire logic [N_IN-1:0] sw_req,
    input  wire logic            key_req,
    input  wire logic            prun_req,
    input  wire logic            srun_req,
    output logic      [N_IN-1:0] sw_o = '0,
    output logic                 key_o = 1'b0,
    output logic                 prun_o = 1'b0,
    output logic                 srun_o = 1'b0
);
    // ------------------------------------------------------------
    // Contact levels
    // ------------------------------------------------------------
    // Contacts settle one edge after the operator moves them; no bounce modelled
    always @(posedge mclk) begin
        sw_o   <= sw_req;
        key_o  <= key_req;
        prun_o <= prun_req;
        srun_o <= srun_req; // Run may rise together with hold
    end
endmodule // itc_contacts

// *** verif/testbench.sv ***
// Self-checking testbench for the input terminal command logic
`timescale 1ns/100ps
module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int N = 10;
    logic          mclk = 1'b0;
    logic          srst = 1'b1;
    logic          cyc = 1'b0;
    logic          we = 1'b0;
    logic [3:0]    sel = 4'hF;
    logic [7:0]    adr = 8'h00;
    logic [31:0]   wdat = 32'h0;
    logic [31:0]   rdat, dat_o;
    logic          ack, key_req = 1'b0, prun_req = 1'b0, srun_req = 1'b0;
    logic          comm_run = 1'b0, opt_run = 1'b0, key, prun, srun;
    logic [N-1:0]  sw_req = '0, term;
    logic [15:0]   fin [6] = '{default: 16'h0000};
    logic          run_o, loc_o, inh_o, sreq_o, hold_o, err_o;
    logic [15:0]   fref_o, sfreq_o, hfreq_o, v, w;
    logic [31:0]   seed = 32'h2E85D31B;
    int            n_errors = 0, n_tests = 0, cycles = 0, cnt;

    always #10 mclk = ~mclk;

    itc_contacts #(.N_IN(N)) itc_contacts_inst (.mclk(mclk), .sw_req(sw_req),
        .key_req(key_req), .prun_req(prun_req), .srun_req(srun_req), .sw_o(term),
        .key_o(key), .prun_o(prun), .srun_o(srun));

    itc_top #(.N_IN(N), .FREQ_W(16)) itc_top_inst (.mclk(mclk), .srst(srst),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .multi_input_terminals(term),
        .panel_key_in(key), .panel_run_in(prun), .seq_run_in(srun), .comm_run_i(comm_run),
        .opt_run_i(opt_run), .panel_freq_i(fin[0]), .analog_freq_i(fin[1]),
        .comm_freq_i(fin[2]), .opt_freq_i(fin[3]), .pulse_freq_i(fin[4]),
        .out_freq_i(fin[5]), .run_cmd_o(run_o), .freq_ref_o(fref_o),
        .local_mode_o(loc_o), .out_inhibit_o(inh_o), .search_req_o(sreq_o),
        .search_freq_o(sfreq_o), .ramp_hold_o(hold_o), .hold_freq_o(hfreq_o),
        .invalid_input_sel_error_o(err_o));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ctrl(input logic [2:0] f, input logic [1:0] r,
                                         input logic m);
        return (32'(m) << 8) | (32'(r) << 4) | 32'(f);
    endfunction

    // Panel wins in local; otherwise the source code indexes the reference inputs
    function automatic logic [15:0] exp_ref(input logic loc, input logic [2:0] src);
        return loc ? fin[0] : fin[src];
    endfunction

    function automatic logic exp_run(input logic loc, input logic [1:0] src);
        logic [3:0] r;
        r = {opt_run, comm_run, srun_req, prun_req};
        return loc ? prun_req : r[src];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Classic single cycle; only the bench timeout ends a wait for ack
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc  <= 1'b1;
        we   <= wr;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic press();
        key_req <= 1'b1;
        tick(6);
        key_req <= 1'b0;
        tick(6);
    endtask

    task automatic count_pulses();
        cnt = 0;
        repeat (12) begin
            @(posedge mclk);
            if (sreq_o === 1'b1) cnt++;
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under two thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(5);
        srst <= 1'b0;
        bus(1'b0, itc_pkg::ADR_CTRL, 32'h0);
        chk(rdat, 32'h11);
        bus(1'b1, 8'h20, 32'hFFFFFFFF);
        bus(1'b0, 8'h20, 32'h0);
        chk(rdat, 32'h0);
        $display("test reset done");
        // Every reference code, run codes wrap over 0..3
        for (int s = 0; s < 5; s++) begin
            for (int i = 0; i < 5; i++) fin[i] <= 16'(xs());
            comm_run <= 1'(xs());
            opt_run  <= 1'(xs());
            srun_req <= 1'(xs());
            prun_req <= 1'(xs());
            bus(1'b1, itc_pkg::ADR_CTRL, ctrl(3'(s), 2'(s), 1'b0));
            tick(6);
            chk(fref_o, exp_ref(1'b0, 3'(s)));
            chk(run_o, exp_run(1'b0, 2'(s)));
        end
        bus(1'b1, itc_pkg::ADR_CTRL, ctrl(3'h5, 2'h1, 1'b0));
        bus(1'b0, itc_pkg::ADR_CTRL, 32'h0);
        chk(rdat, 32'h14);
        $display("test sources done");
        // Terminal 0 takes the local/remote function; key must be dead meanwhile
        bus(1'b1, itc_pkg::ADR_CTRL, ctrl(3'h1, 2'h1, 1'b0));
        bus(1'b1, itc_pkg::ADR_FSEL0, 32'h0F0F0F01);
        prun_req <= 1'b1;
        sw_req[0] <= 1'b1;
        tick(6);
        chk(loc_o, 32'h1);
        chk(fref_o, exp_ref(1'b1, 3'h1));
        chk(run_o, exp_run(1'b1, 2'h1));
        press();
        chk(loc_o, 32'h1);
        sw_req[0] <= 1'b0;
        tick(6);
        chk(loc_o, 32'h0);
        chk(fref_o, exp_ref(1'b0, 3'h1));
        bus(1'b1, itc_pkg::ADR_FSEL0, 32'h0F0F0F0F);
        press();
        chk(loc_o, 32'h1);
        press();
        chk(loc_o, 32'h0);
        $display("test local done");
        // Normally-open baseblock on terminal 1, reference moves while blocked
        bus(1'b1, itc_pkg::ADR_FSEL0, 32'h0F0F080F);
        v = fin[1];
        sw_req[1] <= 1'b1;
        tick(6);
        chk(inh_o, 32'h1);
        fin[1] <= v ^ 16'h5A5A;
        tick(2);
        sw_req[1] <= 1'b0;
        count_pulses();
        chk(32'(cnt), 32'h1);
        chk(inh_o, 32'h0);
        chk(sfreq_o, v);
        // Normally-closed form blocks while the contact is open
        bus(1'b1, itc_pkg::ADR_FSEL0, 32'h0F0F090F);
        tick(6);
        chk(inh_o, 32'h1);
        sw_req[1] <= 1'b1;
        count_pulses();
        chk(32'(cnt), 32'h1);
        chk(inh_o, 32'h0);
        $display("test baseblock done");
        // Ramp hold on terminal 2, memory off
        // Stop the run first so its falling edge cannot clear the capture
        srun_req <= 1'b0;
        bus(1'b1, itc_pkg::ADR_FSEL0, 32'h0F0A0F0F);
        v = 16'(xs()) | 16'h0001;
        fin[5] <= v;
        sw_req[2] <= 1'b1;
        tick(6);
        chk(hold_o, 32'h1);
        fin[5] <= ~v;
        tick(3);
        chk(hfreq_o, v);
        srun_req <= 1'b1;
        tick(6);
        chk(hfreq_o, 32'h0);
        srun_req <= 1'b0;
        sw_req[2] <= 1'b0;
        tick(6);
        chk(hold_o, 32'h0);
        // Memory on: held value survives a reset and returns with run plus hold
        bus(1'b1, itc_pkg::ADR_CTRL, ctrl(3'h1, 2'h1, 1'b1));
        fin[5] <= v;
        sw_req[2] <= 1'b1;
        tick(6);
        sw_req[2] <= 1'b0;
        srst <= 1'b1;
        tick(2);
        srst <= 1'b0;
        bus(1'b0, itc_pkg::ADR_HOLDF, 32'h0);
        chk(rdat, 32'(v));
        bus(1'b1, itc_pkg::ADR_CTRL, ctrl(3'h1, 2'h1, 1'b1));
        bus(1'b1, itc_pkg::ADR_FSEL0, 32'h0F0A0F0F);
        fin[5] <= v ^ 16'h5A5A;
        sw_req[2] <= 1'b1;
        srun_req <= 1'b1;
        tick(6);
        chk(hfreq_o, v);
        $display("test hold done");
        // Hold together with an up command is an invalid selection
        // Only byte lane 3 is enabled, so the hold code in lane 2 must survive
        sel <= 4'h8;
        bus(1'b1, itc_pkg::ADR_FSEL0, 32'h10FFFFFF);
        sel <= 4'hF;
        tick(4);
        chk(err_o, 32'h1);
        bus(1'b1, itc_pkg::ADR_FSEL0, 32'h0F0F0F0F);
        tick(4);
        chk(err_o, 32'h0);
        // Memory is dead once hold is unassigned, so a stop clears the held value
        srun_req <= 1'b0;
        tick(6);
        chk(hfreq_o, 32'h0);
        $display("test error done");
        tally_and_finish();
    end
endmodule // testbench
